/* simdp_pkg.sv */
// Purpose: shared constants for the lane-enable mask generator
// Assumes: 16 lanes, two 16-bit flag subregisters, 32-bit APB data
// Notes:   selection encodings below are fixed for this block
package simdp_pkg;
   localparam int LANES = 16;
   // predicate_select_field encodings (4 bits)
   localparam logic [3:0] SEL_NONE   = 4'h0; // no predication, all lanes on
   localparam logic [3:0] SEL_SEQ    = 4'h1; // sequential flag mapping
   localparam logic [3:0] SEL_REP_X  = 4'h2; // replicate offset 0 of each quad
   localparam logic [3:0] SEL_REP_Y  = 4'h3;
   localparam logic [3:0] SEL_REP_Z  = 4'h4;
   localparam logic [3:0] SEL_REP_W  = 4'h5;
   localparam logic [3:0] SEL_ANY4   = 4'h6; // group4_or_select
   localparam logic [3:0] SEL_ALL4   = 4'h7; // group4_and_select
   localparam logic [3:0] SEL_ANY2   = 4'h8;
   localparam logic [3:0] SEL_ALL2   = 4'h9;
   localparam logic [3:0] SEL_ANY8   = 4'hA;
   localparam logic [3:0] SEL_ALL8   = 4'hB;
   localparam logic [3:0] SEL_ANY16  = 4'hC;
   localparam logic [3:0] SEL_ALL16  = 4'hD;
   localparam logic [3:0] SEL_VAND   = 4'hE; // vertical AND of both subregisters
   localparam logic [3:0] SEL_VOR    = 4'hF; // vertical OR of both subregisters
   // access modes
   localparam logic MODE_BYTE  = 1'b0; // byte_aligned_mode
   localparam logic MODE_QUAD  = 1'b1; // four_lane_aligned_mode
   // register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_FLAG   = 8'h04;
   localparam logic [7:0] OFS_MASK   = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   // control, flag and status register fields
   localparam int CTRL_OVR_BIT  = 0;
   localparam int CTRL_SEL_LSB  = 4;
   localparam int CTRL_INV_BIT  = 8;
   localparam int CTRL_MODE_BIT = 9;
   localparam int CTRL_SUB_BIT  = 10;
   localparam int FLAG_HI_LSB   = 16;
   localparam int STAT_UNDEF_BIT = 0;
   // reset values and the all-off mask
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] FLAG_RST = 32'h0000_0000;
   localparam logic [15:0] MASK_RST = 16'hFFFF;
   localparam logic [15:0] MASK_OFF = 16'h0000;
endpackage

/* simdp_group_reduce.sv */
// Purpose: reduce flag bits over aligned groups and replicate the result
// Assumes: group size is a power of two dividing 16
// Notes:   one instance per group size; pure combinational
module simdp_group_reduce #(
   parameter int GSIZE = 4
) (
   input  wire logic [15:0] flags,    // selected flag subregister
   output logic      [15:0] or_mask,  // per-group OR, replicated
   output logic      [15:0] and_mask  // per-group AND, replicated
);
   // each group reduces on its own slice, then fans the bit back out
   for (genvar g = 0; g < 16 / GSIZE; g++) begin : grp
      assign or_mask[g*GSIZE +: GSIZE]  = {GSIZE{|flags[g*GSIZE +: GSIZE]}};
      assign and_mask[g*GSIZE +: GSIZE] = {GSIZE{&flags[g*GSIZE +: GSIZE]}};
   end
endmodule // simdp_group_reduce

/* simdp_mask_gen.sv */
// Purpose: build the 16-lane enable mask for predicated SIMD execution
// Assumes: decode inputs come from logic on SYS_CLK; APB slave for test/control
// Notes:   mask is registered, so it follows the decode inputs by one cycle
//
// The APB slave port and the register addresses were decided locally.

module simdp_mask_gen (
   input  wire logic        SYS_CLK,          // 25 MHz clock
   input  wire logic        SRST,             // synchronous reset, high
   input  wire logic [3:0]  PRED_SELECT,      // predicate_select_field from decoder
   input  wire logic        PRED_INVERT,      // predicate_invert_field from decoder
   input  wire logic        ACCESS_MODE,      // 1 four_lane_aligned, 0 byte_aligned
   input  wire logic        FLAG_SUBREG_SEL,  // 0 low, 1 high subregister
   input  wire logic [15:0] FLAG_SUBREG_LOW,  // flag_subreg_low
   input  wire logic [15:0] FLAG_SUBREG_HIGH, // flag_subreg_high
   output logic      [15:0] LANE_ENABLE_MASK, // lane_enable_mask to channels
   input  wire logic        PSEL,             // APB select
   input  wire logic        PENABLE,          // APB access phase
   input  wire logic        PWRITE,           // APB direction
   input  wire logic [7:0]  PADDR,            // APB byte address
   input  wire logic [31:0] PWDATA,           // APB write data
   output logic      [31:0] PRDATA,           // APB read data
   output logic             PREADY,           // APB ready
   output logic             PSLVERR           // APB error on unmapped offset
);
   logic [31:0] ctrl;        // override and software decode fields
   logic [31:0] flag;        // software flag subregisters
   logic        undef_seen;  // sticky: undefined selection met
   logic        addr_ok;
   logic        wr_acc;
   logic [3:0]  eff_sel;
   logic        eff_inv;
   logic        eff_mode;
   logic        eff_sub;
   logic [15:0] eff_lo;
   logic [15:0] eff_hi;
   logic [15:0] sel_flags;
   logic [15:0] red_or [4];
   logic [15:0] red_and [4];
   logic [15:0] rep [4];
   logic [15:0] horiz;
   logic [15:0] vert;
   logic [15:0] mux_a;
   logic [15:0] inv_out;
   logic        use_vert;
   logic        sel_defined;
   logic [15:0] next_mask;

   // ---------------- APB slave ----------------
   // zero wait states; read data is captured in the setup cycle
   assign PREADY  = 1'b1;
   assign addr_ok = (PADDR == simdp_pkg::OFS_CTRL) || (PADDR == simdp_pkg::OFS_FLAG) ||
                    (PADDR == simdp_pkg::OFS_MASK) || (PADDR == simdp_pkg::OFS_STATUS);
   assign PSLVERR = PSEL && PENABLE && !addr_ok;
   assign wr_acc  = PSEL && PENABLE && PWRITE && addr_ok;

   // control register, steers the source of the decode fields
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         ctrl <= simdp_pkg::CTRL_RST;
      end else if (wr_acc && PADDR == simdp_pkg::OFS_CTRL) begin
         ctrl <= PWDATA;
      end
   end

   // software flag subregisters, used only under override
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         flag <= simdp_pkg::FLAG_RST;
      end else if (wr_acc && PADDR == simdp_pkg::OFS_FLAG) begin
         flag <= PWDATA;
      end
   end

   // sticky undefined-selection flag; a new event wins over write-one-to-clear
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         undef_seen <= 1'b0;
      end else if (!sel_defined) begin
         undef_seen <= 1'b1;
      end else if (wr_acc && PADDR == simdp_pkg::OFS_STATUS &&
                   PWDATA[simdp_pkg::STAT_UNDEF_BIT]) begin
         undef_seen <= 1'b0;
      end
   end

   // read data registered in setup phase, held through the access phase
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         PRDATA <= 32'h0000_0000;
      end else if (PSEL && !PENABLE && !PWRITE) begin
         case (PADDR)
            simdp_pkg::OFS_CTRL:   PRDATA <= ctrl;
            simdp_pkg::OFS_FLAG:   PRDATA <= flag;
            simdp_pkg::OFS_MASK:   PRDATA <= {16'h0000, LANE_ENABLE_MASK};
            simdp_pkg::OFS_STATUS: PRDATA <= {31'h0000_0000, undef_seen};
            default:               PRDATA <= 32'h0000_0000;
         endcase
      end
   end

   // ---------------- mask datapath ----------------
   // the select, invert, access mode, flag source and both flag subregisters reach the mask; the override
   // swaps the decoder pins for software copies of all of those, flag data included
   always_comb begin
      if (ctrl[simdp_pkg::CTRL_OVR_BIT]) begin
         eff_sel  = ctrl[simdp_pkg::CTRL_SEL_LSB +: 4];
         eff_inv  = ctrl[simdp_pkg::CTRL_INV_BIT];
         eff_mode = ctrl[simdp_pkg::CTRL_MODE_BIT];
         eff_sub  = ctrl[simdp_pkg::CTRL_SUB_BIT];
         eff_lo   = flag[15:0];
         eff_hi   = flag[simdp_pkg::FLAG_HI_LSB +: 16];
      end else begin
         eff_sel  = PRED_SELECT;
         eff_inv  = PRED_INVERT;
         eff_mode = ACCESS_MODE;
         eff_sub  = FLAG_SUBREG_SEL;
         eff_lo   = FLAG_SUBREG_LOW;
         eff_hi   = FLAG_SUBREG_HIGH;
      end
   end

   // horizontal paths see one subregister only
   assign sel_flags = eff_sub ? eff_hi : eff_lo;

   // group reducers for sizes 2, 4, 8 and 16
   for (genvar s = 0; s < 4; s++) begin : red
      simdp_group_reduce #(.GSIZE(2 << s)) u_red (
         .flags    (sel_flags),
         .or_mask  (red_or[s]),
         .and_mask (red_and[s])
      );
   end

   // quad replication of offset k within each aligned group of four
   for (genvar k = 0; k < 4; k++) begin : repk
      for (genvar q = 0; q < 4; q++) begin : quad
         assign rep[k][q*4 +: 4] = {4{sel_flags[q*4 + k]}};
      end
   end

   // vertical combination, lane by lane across both subregisters
   assign vert = (eff_sel == simdp_pkg::SEL_VAND) ? (eff_lo & eff_hi)
                                                  : (eff_lo | eff_hi);

   // horizontal selection; mode decides which groupings exist
   always_comb begin
      horiz       = simdp_pkg::MASK_OFF;
      sel_defined = 1'b1;
      use_vert    = 1'b0;
      case (eff_sel)
         simdp_pkg::SEL_NONE:  horiz = simdp_pkg::MASK_OFF;
         simdp_pkg::SEL_SEQ:   horiz = sel_flags;
         simdp_pkg::SEL_REP_X,
         simdp_pkg::SEL_REP_Y,
         simdp_pkg::SEL_REP_Z,
         simdp_pkg::SEL_REP_W: begin
            if (eff_mode == simdp_pkg::MODE_QUAD) begin
               horiz = rep[2'(eff_sel - simdp_pkg::SEL_REP_X)];
            end else begin
               sel_defined = 1'b0;
            end
         end
         simdp_pkg::SEL_ANY4:  horiz = red_or[1];
         simdp_pkg::SEL_ALL4:  horiz = red_and[1];
         simdp_pkg::SEL_ANY2,
         simdp_pkg::SEL_ALL2,
         simdp_pkg::SEL_ANY8,
         simdp_pkg::SEL_ALL8,
         simdp_pkg::SEL_ANY16,
         simdp_pkg::SEL_ALL16: begin
            // wider and narrower groups exist only in byte mode
            if (eff_mode == simdp_pkg::MODE_BYTE) begin
               case (eff_sel)
                  simdp_pkg::SEL_ANY2:  horiz = red_or[0];
                  simdp_pkg::SEL_ALL2:  horiz = red_and[0];
                  simdp_pkg::SEL_ANY8:  horiz = red_or[2];
                  simdp_pkg::SEL_ALL8:  horiz = red_and[2];
                  simdp_pkg::SEL_ANY16: horiz = red_or[3];
                  default:              horiz = red_and[3];
               endcase
            end else begin
               sel_defined = 1'b0;
            end
         end
         simdp_pkg::SEL_VAND,
         simdp_pkg::SEL_VOR:   use_vert = 1'b1;
         default:              sel_defined = 1'b0;
      endcase
   end

   // selector between horizontal and vertical, then inversion
   assign mux_a   = use_vert ? vert : horiz;
   assign inv_out = eff_inv ? ~mux_a : mux_a;

   // bypass: no predication forces all lanes on; an undefined choice fails safe
   // by disabling every lane rather than running unpredicated
   always_comb begin
      if (eff_sel == simdp_pkg::SEL_NONE) begin
         next_mask = simdp_pkg::MASK_RST;
      end else if (!sel_defined) begin
         next_mask = simdp_pkg::MASK_OFF;
      end else begin
         next_mask = inv_out;
      end
   end

   // registered mask drives the lane gates
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         LANE_ENABLE_MASK <= simdp_pkg::MASK_RST;
      end else begin
         LANE_ENABLE_MASK <= next_mask;
      end
   end

   // ---------------- assertions ----------------
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SRST);

   bypass_all_on_a: assert property (
      eff_sel == simdp_pkg::SEL_NONE |=> LANE_ENABLE_MASK == 16'hFFFF)
      else $error("no predication did not enable all lanes");

   seq_mapping_a: assert property (
      eff_sel == simdp_pkg::SEL_SEQ |=>
         LANE_ENABLE_MASK == ($past(eff_inv) ? ~$past(sel_flags) : $past(sel_flags)))
      else $error("sequential mapping mismatch");

   subreg_pick_a: assert property (
      eff_sel == simdp_pkg::SEL_SEQ && !eff_inv && eff_sub |=>
         LANE_ENABLE_MASK == $past(eff_hi))
      else $error("high subregister not used");

   quad_rep_x_a: assert property (
      eff_sel == simdp_pkg::SEL_REP_X && eff_mode == simdp_pkg::MODE_QUAD && !eff_inv |=>
         LANE_ENABLE_MASK[7:4] == {4{$past(sel_flags[4])}})
      else $error("replicate offset 0 wrong in quad 1");

   quad_rep_w_a: assert property (
      eff_sel == simdp_pkg::SEL_REP_W && eff_mode == simdp_pkg::MODE_QUAD && !eff_inv |=>
         LANE_ENABLE_MASK[15:12] == {4{$past(sel_flags[15])}})
      else $error("replicate offset 3 wrong in quad 3");

   quad_or_a: assert property (
      eff_sel == simdp_pkg::SEL_ANY4 && !eff_inv |=>
         LANE_ENABLE_MASK[3:0] == {4{|$past(sel_flags[3:0])}})
      else $error("quad OR wrong");

   quad_and_inv_a: assert property (
      eff_sel == simdp_pkg::SEL_ALL4 && eff_inv |=>
         LANE_ENABLE_MASK[11:8] == {4{~&$past(sel_flags[11:8])}})
      else $error("inverted quad AND wrong");

   byte_group8_a: assert property (
      eff_sel == simdp_pkg::SEL_ALL8 && eff_mode == simdp_pkg::MODE_BYTE && !eff_inv |=>
         LANE_ENABLE_MASK == {{8{&$past(sel_flags[15:8])}}, {8{&$past(sel_flags[7:0])}}})
      else $error("byte mode group of 8 wrong");

   vert_inv_a: assert property (
      eff_sel == simdp_pkg::SEL_VOR && eff_inv |=>
         LANE_ENABLE_MASK == ~($past(eff_lo) | $past(eff_hi)))
      else $error("inverted vertical OR wrong");

   undef_off_a: assert property (
      eff_sel == simdp_pkg::SEL_ANY16 && eff_mode == simdp_pkg::MODE_QUAD |=>
         LANE_ENABLE_MASK == 16'h0000 && undef_seen)
      else $error("undefined selection not disabled");

   quad_rep_y_inv_a: assert property (
      eff_sel == simdp_pkg::SEL_REP_Y && eff_mode == simdp_pkg::MODE_QUAD && eff_inv |=>
         LANE_ENABLE_MASK[3:0] == {4{~$past(sel_flags[1])}})
      else $error("inverted replicate offset 1 wrong in quad 0");

   quad_rep_z_a: assert property (
      eff_sel == simdp_pkg::SEL_REP_Z && eff_mode == simdp_pkg::MODE_QUAD && !eff_inv |=>
         LANE_ENABLE_MASK[11:8] == {4{$past(sel_flags[10])}})
      else $error("replicate offset 2 wrong in quad 2");

   quad_and_byte_a: assert property (
      eff_sel == simdp_pkg::SEL_ALL4 && eff_mode == simdp_pkg::MODE_BYTE && !eff_inv |=>
         LANE_ENABLE_MASK[15:12] == {4{&$past(sel_flags[15:12])}})
      else $error("byte mode group of 4 AND wrong");

   byte_or2_a: assert property (
      eff_sel == simdp_pkg::SEL_ANY2 && eff_mode == simdp_pkg::MODE_BYTE && !eff_inv |=>
         LANE_ENABLE_MASK[15:14] == {2{|$past(sel_flags[15:14])}})
      else $error("byte mode group of 2 OR wrong");

   byte_or16_inv_a: assert property (
      eff_sel == simdp_pkg::SEL_ANY16 && eff_mode == simdp_pkg::MODE_BYTE && eff_inv |=>
         LANE_ENABLE_MASK == {16{~|$past(sel_flags)}})
      else $error("inverted byte mode group of 16 OR wrong");

   byte_and16_a: assert property (
      eff_sel == simdp_pkg::SEL_ALL16 && eff_mode == simdp_pkg::MODE_BYTE && !eff_inv |=>
         LANE_ENABLE_MASK == {16{&$past(sel_flags)}})
      else $error("byte mode group of 16 AND wrong");

   seq_low_a: assert property (
      eff_sel == simdp_pkg::SEL_SEQ && !eff_inv && !eff_sub |=>
         LANE_ENABLE_MASK == $past(eff_lo))
      else $error("low subregister not used");

   vert_and_a: assert property (
      eff_sel == simdp_pkg::SEL_VAND && !eff_inv |=>
         LANE_ENABLE_MASK == ($past(eff_lo) & $past(eff_hi)))
      else $error("vertical AND wrong");

   vert_or_a: assert property (
      eff_sel == simdp_pkg::SEL_VOR && !eff_inv |=>
         LANE_ENABLE_MASK == ($past(eff_lo) | $past(eff_hi)))
      else $error("vertical OR wrong");

   rep_byte_off_a: assert property (
      eff_sel >= simdp_pkg::SEL_REP_X && eff_sel <= simdp_pkg::SEL_REP_W &&
      eff_mode == simdp_pkg::MODE_BYTE |=> LANE_ENABLE_MASK == 16'h0000 && undef_seen)
      else $error("replicate in byte mode not disabled");

   undef_hold_a: assert property (
      undef_seen && !(wr_acc && PADDR == simdp_pkg::OFS_STATUS &&
      PWDATA[simdp_pkg::STAT_UNDEF_BIT]) |=> undef_seen)
      else $error("undefined-selection flag dropped without a clear");

   undef_clear_a: assert property (
      sel_defined && wr_acc && PADDR == simdp_pkg::OFS_STATUS &&
      PWDATA[simdp_pkg::STAT_UNDEF_BIT] |=> !undef_seen)
      else $error("undefined-selection flag not cleared");

   cov_quad_rep: cover property (eff_sel == simdp_pkg::SEL_REP_Y &&
                                 eff_mode == simdp_pkg::MODE_QUAD);
   cov_vert_and: cover property (eff_sel == simdp_pkg::SEL_VAND ##1
                                 eff_sel == simdp_pkg::SEL_VOR);
   cov_undef_clear: cover property (undef_seen ##1 !undef_seen);
   cov_byte16:   cover property (eff_sel == simdp_pkg::SEL_ANY16 &&
                                 eff_mode == simdp_pkg::MODE_BYTE && eff_inv);
endmodule // simdp_mask_gen

/* simdp_dec_model.sv */
// Purpose: decoder-side model driving the predicate fields and flag subregisters
// Assumes: one request per call, launched just after a rising edge
// Notes:   fields hold until the next call, like a decoded instruction word
module simdp_dec_model (
   input  wire logic        clk,  // system clock
   output logic      [3:0]  sel,  // predicate_select_field
   output logic             inv,  // predicate_invert_field
   output logic             mode, // access mode
   output logic             sub,  // subregister choice
   output logic      [15:0] lo,   // flag_subreg_low
   output logic      [15:0] hi    // flag_subreg_high
);
   timeunit 1ns;
   timeprecision 1ps;
   // defined values at time zero so the mask never sees unknowns
   initial begin
      {sel, inv, mode, sub, lo, hi} = '0;
   end
   // issue one decoded instruction at the next rising edge
   task automatic issue(input logic [3:0] s, input logic i, m, b, input logic [15:0] l, h);
      @(posedge clk);
      sel  <= s;
      inv  <= i;
      mode <= m;
      sub  <= b;
      lo   <= l;
      hi   <= h;
   endtask
endmodule // simdp_dec_model

/* simd_predicate_mask_gen_tb.sv */
// Purpose: self-checking bench for the lane-enable mask generator
// Assumes: mask lags decode inputs by one cycle; apb answers at once
// Notes:   expected masks come from an integer model written here
module simd_predicate_mask_gen_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk, srst, psel, penable, pwrite, pready, pslverr;
   logic [3:0]  pred_sel;
   logic        pred_inv, acc_mode, sub_sel;
   logic [15:0] flag_lo, flag_hi, lane_mask;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        err;
   logic [16:0] exp_now, exp_prev;
   int          mismatches, check_count, cycles;
   logic [15:0] l, h;

   simdp_dec_model i_dec (.clk(sys_clk), .sel(pred_sel), .inv(pred_inv), .mode(acc_mode),
      .sub(sub_sel), .lo(flag_lo), .hi(flag_hi));
   simdp_mask_gen i_dut (.SYS_CLK(sys_clk), .SRST(srst), .PRED_SELECT(pred_sel),
      .PRED_INVERT(pred_inv), .ACCESS_MODE(acc_mode), .FLAG_SUBREG_SEL(sub_sel),
      .FLAG_SUBREG_LOW(flag_lo), .FLAG_SUBREG_HIGH(flag_hi), .LANE_ENABLE_MASK(lane_mask),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));

   // 25 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         mismatches++;
         end_sim();
      end
   end

   task automatic end_sim();
      if (mismatches == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one apb transfer; read data and error are taken at the edge that sees pready high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // no wait count assumed; only the hang guard ends a stuck access
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // reference mask: bit 16 flags a selection undefined for the mode
   function automatic logic [16:0] ref_mask(input int s, inv, md, sb, input logic [15:0] lo, hi);
      logic [15:0] f, m;
      int g, b, ch, k;
      f = sb ? hi : lo;
      m = 16'h0000;
      if (s == 0) return {1'b0, 16'hFFFF};
      if ((md == 1 && s >= 8 && s <= 13) || (md == 0 && s >= 2 && s <= 5))
         return {1'b1, 16'h0000};
      if (s == 14) m = lo & hi;
      else if (s == 15) m = lo | hi;
      else if (s == 1) m = f;
      else if (s <= 5) for (ch = 0; ch < 16; ch++) m[ch] = f[(ch / 4) * 4 + s - 2];
      else begin
         g = (s <= 7) ? 4 : (s <= 9) ? 2 : (s <= 11) ? 8 : 16;
         for (ch = 0; ch < 16; ch++) begin
            b = s % 2;
            for (k = (ch / g) * g; k < (ch / g) * g + g; k++)
               b = (s % 2 == 0) ? (b | f[k]) : (b & f[k]);
            m[ch] = b[0];
         end
      end
      return {1'b0, inv ? ~m : m};
   endfunction

   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      srst        = 1'b1;
      mismatches  = 0;
      check_count = 0;
      cycles      = 0;
      exp_prev    = {1'b0, 16'hFFFF};
      void'($urandom(6098));
      repeat (16) @(posedge sys_clk);
      srst <= 1'b0;
      @(negedge sys_clk);
      chk("mask reset", 32'h0000_FFFF, {16'h0000, lane_mask});
      apb(1'b0, 8'h00, 32'h0);
      chk("ctrl reset", 32'h0, rd);
      apb(1'b0, 8'h04, 32'h0);
      chk("flag reset", 32'h0, rd);
      // every select code in both modes, both inversions, back to back
      for (int rep = 0; rep < 3; rep++)
         for (int s = 0; s < 16; s++)
            for (int md = 0; md < 2; md++)
               for (int iv = 0; iv < 2; iv++) begin
                  l = (rep == 0) ? 16'hFFFF : (rep == 1) ? 16'h0000 : 16'($urandom);
                  h = (rep == 0) ? 16'h0000 : 16'($urandom);
                  k_issue(s, iv, md, int'($urandom % 2));
               end
      @(negedge sys_clk);
      chk("mask", {16'h0, exp_prev[15:0]}, {16'h0, lane_mask}); // lane mask
      apb(1'b0, 8'h0C, 32'h0);
      chk("status sticky", 32'h1, rd & 32'h1); // undefined pick
      // software override path uses the same evaluation
      apb(1'b1, 8'h04, 32'h00F0_0F01);
      apb(1'b1, 8'h00, 32'h0000_0261);
      apb(1'b1, 8'h08, 32'h0);
      apb(1'b0, 8'h08, 32'h0);
      exp_now = ref_mask(6, 0, 1, 0, 16'h0F01, 16'h00F0);
      chk("mask reg", {16'h0000, exp_now[15:0]}, rd & 32'h0000_FFFF); // quad OR
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h0C, 32'h1);
      apb(1'b0, 8'h0C, 32'h0);
      chk("status clear", 32'h0, rd & 32'h1);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      apb(1'b1, 8'h14, 32'h5);
      chk("unmapped wr err", 32'h1, {31'h0, err});
      end_sim();
   end

   // launch one vector and compare the one launched a cycle earlier
   task automatic k_issue(input int s, iv, md, sb);
      i_dec.issue(4'(s), iv[0], md[0], sb[0], l, h);
      exp_now = ref_mask(s, iv, md, sb, l, h);
      @(negedge sys_clk);
      chk("mask", {16'h0, exp_prev[15:0]}, {16'h0, lane_mask});
      exp_prev = exp_now;
   endtask
endmodule // simd_predicate_mask_gen_tb
